// *** core/tiu_pkg.sv ***
/*
  shared constants of the translation buffer invalidation unit:
  mmu type and invalidate support codes, state codes, ways field bias.
  assumes nothing of its surroundings.
*/
package tiu_pkg;
  // mmu type field codes
  localparam logic [2:0] TIU_MT_JOINT = 3'h1;
  localparam logic [2:0] TIU_MT_BLOCK = 3'h2;
  localparam logic [2:0] TIU_MT_FIXMAP = 3'h3;
  localparam logic [2:0] TIU_MT_SPLIT = 3'h4;
  // invalidate support field codes
  localparam logic [1:0] TIU_IE_NONE = 2'h0;
  localparam logic [1:0] TIU_IE_SW = 2'h2;
  localparam logic [1:0] TIU_IE_HW = 2'h3;
  // ways field is the way count less this bias
  localparam int TIU_WAYS_BIAS = 2;
  // walk state machine, one-hot
  typedef enum logic [1:0] {
    TIU_IDLE = 2'b01,
    TIU_WALK = 2'b10
  } tiu_state_t;
endpackage

// *** core/tiu_entry.sv ***
/*
  one translation entry's tag, global and invalid flops plus its
  invalidate match test. assumes writes never overlap a walk.
*/
`timescale 1ns/10ps
`default_nettype none
module tiu_entry #(
  parameter int TAG_W = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [TAG_W-1:0] wr_tag,
  input wire logic wr_global,
  input wire logic sel,
  input wire logic flush,
  input wire logic [TAG_W-1:0] tag_ref,
  output logic hit,
  output logic invalid
);
  logic [TAG_W-1:0] tag_r, tag_nxt;
  logic global_r, global_nxt;
  logic inv_r, inv_nxt;

  // page number never enters the test, only tag and global
  always_comb begin
    hit = sel && (flush || (tag_r == tag_ref && !global_r));
  end

  // a write loads a fresh valid entry; a hit marks it invalid
  always_comb begin
    tag_nxt = tag_r;
    global_nxt = global_r;
    inv_nxt = inv_r;
    if (wr_en) begin
      tag_nxt = wr_tag;
      global_nxt = wr_global;
      inv_nxt = 1'b0;
    end
    if (hit) begin
      inv_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tag_r <= '0;
      global_r <= 1'b0;
      inv_r <= 1'b1;
    end else begin
      tag_r <= tag_nxt;
      global_r <= global_nxt;
      inv_r <= inv_nxt;
    end
  end

  assign invalid = inv_r;
endmodule
`default_nettype wire

// *** core/tiu_top.sv ***
/*
  invalidation unit: carries out invalidate-by-space and flush-range
  over an entry array held in flops, one entry per cycle, stalling the
  pipeline while it walks. assumes single-cycle request pulses from the
  pipeline, taken only while busy is low, and a synchronous active high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module tiu_top import tiu_pkg::*; #(
  parameter int TAG_W = 8,
  parameter int VSIZE = 16,
  parameter int WAYS_LOG2 = 2,
  parameter int SETS = 8,
  parameter logic [1:0] IE_SUPPORT = TIU_IE_HW,
  parameter int IW = $clog2(VSIZE + (SETS << WAYS_LOG2))
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic inv_space_req,
  input wire logic flush_req,
  input wire logic priv_enable,
  input wire logic [2:0] mmu_type_field,
  input wire logic [IW-1:0] index_value,
  input wire logic [TAG_W-1:0] address_space_tag,
  input wire logic wr_en,
  input wire logic [IW-1:0] wr_index,
  input wire logic [TAG_W-1:0] wr_tag,
  input wire logic wr_global,
  input wire logic [IW-1:0] rd_index,
  output logic entry_invalid_bit,
  output logic [(VSIZE + (SETS << WAYS_LOG2))-1:0] invalid_vec,
  output logic busy,
  output logic done,
  output logic cop_unusable_exc,
  output logic reserved_instr_exc,
  output logic [1:0] invalidate_support_field,
  output logic [7:0] fixed_page_ways_field,
  output logic [7:0] fixed_page_sets_field
);
  localparam int WAYS = 1 << WAYS_LOG2;
  localparam int N = VSIZE + WAYS * SETS;
  localparam logic [IW-1:0] LAST_ALL = IW'(VSIZE - 1 + WAYS * SETS);
  localparam logic [IW-1:0] LAST_VAR = IW'(VSIZE - 1);
  localparam logic [IW-1:0] VBASE = IW'(VSIZE);
  localparam logic [IW-1:0] WAY_LAST = IW'(WAYS - 1);

  tiu_state_t state_r, state_nxt;
  logic [IW-1:0] cur_r, cur_nxt, end_r, end_nxt;
  logic flush_r, flush_nxt;
  logic [TAG_W-1:0] tag_r, tag_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt;
  logic cpu_r, cpu_nxt, ri_r, ri_nxt;
  logic rd_inv_r;
  logic [1:0] ie_r;
  logic [7:0] ways_r, sets_r;
  logic [N-1:0] hit_vec, inv_vec;
  logic req_any, legal, start;
  logic [IW-1:0] set_base, start_end;

  // decode of the request; checks done in exception priority order
  always_comb begin
    req_any = (inv_space_req || flush_req) && !busy_r;
    legal = (IE_SUPPORT >= TIU_IE_SW) &&
            (mmu_type_field == TIU_MT_JOINT || mmu_type_field == TIU_MT_SPLIT);
    start = req_any && priv_enable && legal;
    set_base = VBASE + (((index_value - VBASE) >> WAYS_LOG2) << WAYS_LOG2);
    // range starts low except a software split fixed-set walk, which starts at set_base; pinned entries get no protection
    if (mmu_type_field == TIU_MT_JOINT) begin
      start_end = LAST_ALL;
    end else if (IE_SUPPORT == TIU_IE_HW) begin
      start_end = LAST_ALL;
    end else if (index_value < VBASE) begin
      start_end = LAST_VAR;
    end else begin
      start_end = set_base + WAY_LAST;
    end
  end

  // walk control: one entry per cycle, busy stalls the pipeline
  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    end_nxt = end_r;
    flush_nxt = flush_r;
    tag_nxt = tag_r;
    done_nxt = 1'b0;
    cpu_nxt = req_any && !priv_enable;
    ri_nxt = req_any && priv_enable && !legal;
    unique case (state_r)
      TIU_IDLE: begin
        if (start) begin
          state_nxt = TIU_WALK;
          flush_nxt = flush_req; // flush wins if both are raised
          tag_nxt = address_space_tag;
          end_nxt = start_end;
          cur_nxt = (mmu_type_field == TIU_MT_SPLIT && IE_SUPPORT == TIU_IE_SW &&
                     index_value >= VBASE) ? set_base : '0;
        end
      end
      TIU_WALK: begin
        if (cur_r == end_r) begin
          state_nxt = TIU_IDLE;
          done_nxt = 1'b1;
        end else begin
          cur_nxt = cur_r + 1'b1;
        end
      end
    endcase
    busy_nxt = (state_nxt == TIU_WALK);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r <= TIU_IDLE;
      cur_r <= '0;
      end_r <= '0;
      flush_r <= 1'b0;
      tag_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      cpu_r <= 1'b0;
      ri_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      end_r <= end_nxt;
      flush_r <= flush_nxt;
      tag_r <= tag_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      cpu_r <= cpu_nxt;
      ri_r <= ri_nxt;
    end
  end

  // entry array; writes are held off during a walk so no flag races
  for (genvar i = 0; i < N; i++) begin : g_ent
    tiu_entry #(.TAG_W(TAG_W)) u_ent (
      .clk_sys(clk_sys),
      .reset(reset),
      .wr_en(wr_en && !busy_r && wr_index == IW'(i)),
      .wr_tag(wr_tag),
      .wr_global(wr_global),
      .sel(state_r == TIU_WALK && cur_r == IW'(i)),
      .flush(flush_r),
      .tag_ref(tag_r),
      .hit(hit_vec[i]),
      .invalid(inv_vec[i])
    );
  end

  // status and configuration readback, registered
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_inv_r <= 1'b0;
      ie_r <= TIU_IE_NONE;
      ways_r <= '0;
      sets_r <= '0;
    end else begin
      rd_inv_r <= inv_vec[rd_index];
      ie_r <= IE_SUPPORT;
      ways_r <= 8'(WAYS - TIU_WAYS_BIAS);
      sets_r <= 8'(SETS);
    end
  end

  assign entry_invalid_bit = rd_inv_r;
  assign invalid_vec = inv_vec;
  assign busy = busy_r;
  assign done = done_r;
  assign cop_unusable_exc = cpu_r;
  assign reserved_instr_exc = ri_r;
  assign invalidate_support_field = ie_r;
  assign fixed_page_ways_field = ways_r;
  assign fixed_page_sets_field = sets_r;

  // checks
  property p_cpu_exc;
    @(posedge clk_sys) disable iff (reset)
    req_any && !priv_enable |=> cpu_r && !busy_r && !ri_r;
  endproperty
  a_cpu_exc: assert property (p_cpu_exc) else $error("no coprocessor unusable");

  property p_ri_exc;
    @(posedge clk_sys) disable iff (reset)
    req_any && priv_enable && (mmu_type_field == TIU_MT_BLOCK || mmu_type_field == TIU_MT_FIXMAP)
      |=> ri_r && !busy_r;
  endproperty
  a_ri_exc: assert property (p_ri_exc) else $error("no reserved instruction");

  property p_busy_start;
    @(posedge clk_sys) disable iff (reset)
    start |=> busy_r && state_r == TIU_WALK;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("walk not started");

  property p_global_kept;
    @(posedge clk_sys) disable iff (reset)
    state_r == TIU_WALK && !flush_r && !hit_vec[cur_r] && !inv_vec[cur_r] |=> !inv_vec[$past(cur_r)];
  endproperty
  a_global_kept: assert property (p_global_kept) else $error("entry wrongly invalidated");

  property p_hit_clears;
    @(posedge clk_sys) disable iff (reset)
    state_r == TIU_WALK && hit_vec[cur_r] |=> inv_vec[$past(cur_r)];
  endproperty
  a_hit_clears: assert property (p_hit_clears) else $error("matching entry kept");

  property p_flush_all;
    @(posedge clk_sys) disable iff (reset)
    state_r == TIU_WALK && flush_r |-> hit_vec[cur_r];
  endproperty
  a_flush_all: assert property (p_flush_all) else $error("flush missed entry");

  property p_joint_full;
    @(posedge clk_sys) disable iff (reset)
    start && mmu_type_field == TIU_MT_JOINT |=> cur_r == '0 && end_r == LAST_ALL;
  endproperty
  a_joint_full: assert property (p_joint_full) else $error("joint range wrong");

  property p_hw_full;
    @(posedge clk_sys) disable iff (reset)
    start && IE_SUPPORT == TIU_IE_HW |=> cur_r == '0 && end_r == LAST_ALL;
  endproperty
  a_hw_full: assert property (p_hw_full) else $error("hardware walk range wrong");

  property p_var_range;
    @(posedge clk_sys) disable iff (reset)
    start && mmu_type_field == TIU_MT_SPLIT && IE_SUPPORT == TIU_IE_SW && index_value < VBASE
      |=> cur_r == '0 && end_r == LAST_VAR;
  endproperty
  a_var_range: assert property (p_var_range) else $error("variable range wrong");

  property p_walk_end;
    @(posedge clk_sys) disable iff (reset)
    state_r == TIU_WALK && cur_r == end_r |=> !busy_r && done_r ##1 !done_r;
  endproperty
  a_walk_end: assert property (p_walk_end) else $error("walk end wrong");

  c_flush: cover property (@(posedge clk_sys) disable iff (reset) start && flush_req ##[1:100] done_r);
  c_space: cover property (@(posedge clk_sys) disable iff (reset) start && !flush_req ##[1:100] done_r);
  c_cpu: cover property (@(posedge clk_sys) disable iff (reset) cpu_r);
  c_ri: cover property (@(posedge clk_sys) disable iff (reset) ri_r);
endmodule
`default_nettype wire

// *** bench/tiu_pipe_model.sv ***
/*
  pipeline side model: issues invalidate-by-space and flush-range pulses.
  assumes the unit's busy output and the bench clock, inputs driven at falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
module tiu_pipe_model #(
  parameter int IW = 3,
  parameter int TAG_W = 8
) (
  input wire logic clk_sys,
  input wire logic busy,
  output logic inv_space_req,
  output logic flush_req,
  output logic priv_enable,
  output logic [2:0] mmu_type_field,
  output logic [IW-1:0] index_value,
  output logic [TAG_W-1:0] address_space_tag
);
  // quiet pipeline until the bench asks for an instruction
  initial begin
    {inv_space_req, flush_req, priv_enable, mmu_type_field} = 6'h08;
    {index_value, address_space_tag} = '0;
  end

  // one-cycle pulse once the unit stalls no more; operands only mean something with it
  task automatic issue(input logic f, input logic [2:0] t, input logic [IW-1:0] idx,
                       input logic [TAG_W-1:0] tag, input logic p);
    @(negedge clk_sys);
    while (busy) @(negedge clk_sys);
    {flush_req, inv_space_req, mmu_type_field, priv_enable} = {f, !f, t, p};
    address_space_tag = tag;
    index_value = idx;
    @(negedge clk_sys);
    {flush_req, inv_space_req} = 2'h0;
    // stale operands flipped so a late sample cannot pass by luck
    index_value = ~idx;
    address_space_tag = ~tag;
  endtask
endmodule
`default_nettype wire

// *** bench/tlb_invalidate_unit_tb_top.sv ***
/*
  self-checking bench of the invalidation unit, 8 entries: a software walk
  unit and a hardware walk twin fed the same requests and writes.
  assumes the pipeline model beside it and tiu_pkg constants.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tlb_invalidate_unit_tb_top import tiu_pkg::*;;
  localparam int VS = 4, WL = 1, W = 2, N = 8, IW = 3;
  logic clk_sys = 1'b0, reset = 1'b1, wr_en = 1'b0, wr_global = 1'b0;
  logic [IW-1:0] wr_index = '0, rd_index = '0, index_value;
  logic [7:0] wr_tag = '0, address_space_tag, fixed_page_ways_field, fixed_page_sets_field, walk_len = '0;
  logic inv_space_req, flush_req, priv_enable, entry_invalid_bit, busy, done, cop_unusable_exc, reserved_instr_exc;
  logic [2:0] mmu_type_field;
  logic [1:0] invalidate_support_field;
  logic [N-1:0] invalid_vec, glob_m, inv_m = '1;
  logic [N-1:0] invalid_vec_hw, inv_h = '1, exp_w;
  logic [N-1:0] exp_h_q [$];
  logic busy_hw, done_hw, busy_any;
  logic [1:0] ie_hw;
  logic [7:0] tag_m [N];
  logic [N+9:0] exp_q [$], exp_v;
  logic [15:0] rnd = 16'hff65;
  logic [2:0] types [6] = '{TIU_MT_JOINT, TIU_MT_SPLIT, TIU_MT_SPLIT, TIU_MT_BLOCK, TIU_MT_FIXMAP, TIU_MT_SPLIT};
  int bad_count = 0, total_checks = 0;

  tiu_top #(.VSIZE(VS), .WAYS_LOG2(WL), .SETS(2), .IE_SUPPORT(TIU_IE_SW)) tiu_top_i (
    .clk_sys(clk_sys), .reset(reset), .inv_space_req(inv_space_req), .flush_req(flush_req),
    .priv_enable(priv_enable), .mmu_type_field(mmu_type_field), .index_value(index_value),
    .address_space_tag(address_space_tag), .wr_en(wr_en), .wr_index(wr_index), .wr_tag(wr_tag),
    .wr_global(wr_global), .rd_index(rd_index), .entry_invalid_bit(entry_invalid_bit),
    .invalid_vec(invalid_vec), .busy(busy), .done(done), .cop_unusable_exc(cop_unusable_exc),
    .reserved_instr_exc(reserved_instr_exc), .invalidate_support_field(invalidate_support_field),
    .fixed_page_ways_field(fixed_page_ways_field), .fixed_page_sets_field(fixed_page_sets_field));

  // hardware walk twin on the same stimulus; every legal request covers the whole array
  tiu_top #(.VSIZE(VS), .WAYS_LOG2(WL), .SETS(2), .IE_SUPPORT(TIU_IE_HW)) tiu_top_hw_i (
    .clk_sys(clk_sys), .reset(reset), .inv_space_req(inv_space_req), .flush_req(flush_req),
    .priv_enable(priv_enable), .mmu_type_field(mmu_type_field), .index_value(index_value),
    .address_space_tag(address_space_tag), .wr_en(wr_en), .wr_index(wr_index), .wr_tag(wr_tag),
    .wr_global(wr_global), .rd_index(rd_index), .entry_invalid_bit(), .invalid_vec(invalid_vec_hw),
    .busy(busy_hw), .done(done_hw), .cop_unusable_exc(), .reserved_instr_exc(),
    .invalidate_support_field(ie_hw), .fixed_page_ways_field(), .fixed_page_sets_field());

  // requests and writes wait for both units, so neither one drops any
  assign busy_any = busy || busy_hw;

  tiu_pipe_model #(.IW(IW)) tiu_pipe_model_i (
    .clk_sys(clk_sys), .busy(busy_any), .inv_space_req(inv_space_req), .flush_req(flush_req),
    .priv_enable(priv_enable), .mmu_type_field(mmu_type_field), .index_value(index_value),
    .address_space_tag(address_space_tag));

  always #25 clk_sys = ~clk_sys;

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // write one entry while idle; short tags so by-space hits often
  // its old invalid flag is read back, registered at the same edge the write lands
  task automatic wr(input int e);
    logic was_inv;
    @(negedge clk_sys);
    while (busy_any) @(negedge clk_sys);
    rnd = lfsr(rnd);
    was_inv = inv_m[e];
    {wr_en, wr_global, wr_tag, rd_index} = {1'b1, rnd[3], 6'h00, rnd[1:0], e[IW-1:0]};
    wr_index = e[IW-1:0];
    {tag_m[e], glob_m[e], inv_m[e], inv_h[e]} = {wr_tag, rnd[3], 2'b00};
    @(negedge clk_sys);
    wr_en = 1'b0;
    `CHK(entry_invalid_bit, was_inv)
  endtask

  // note the reference outcome, then let the pipeline issue it
  task automatic op(input logic f, input logic [2:0] t, input int idx, input logic [7:0] tag, input logic p);
    int lo, hi;
    lo = 0;
    hi = N - 1;
    if (!p) exp_q.push_back({2'b10, 8'h00, inv_m});
    else if (t != TIU_MT_JOINT && t != TIU_MT_SPLIT) exp_q.push_back({2'b01, 8'h00, inv_m});
    else begin
      if (t == TIU_MT_SPLIT && idx < VS) hi = VS - 1;
      else if (t == TIU_MT_SPLIT) begin
        lo = VS + (((idx - VS) >> WL) << WL);
        hi = lo + W - 1;
      end
      for (int i = lo; i <= hi; i++)
        if (f || (tag_m[i] == tag && !glob_m[i])) inv_m[i] = 1'b1;
      exp_q.push_back({2'b00, 8'(hi - lo + 1), inv_m});
      for (int i = 0; i < N; i++)
        if (f || (tag_m[i] == tag && !glob_m[i])) inv_h[i] = 1'b1;
      exp_h_q.push_back(inv_h);
    end
    tiu_pipe_model_i.issue(f, t, idx[IW-1:0], tag, p);
  endtask

  // watcher: busy cycles counted, oldest note compared at each outcome
  always @(negedge clk_sys) begin
    if (busy) walk_len <= walk_len + 8'h01;
    if (done || cop_unusable_exc || reserved_instr_exc) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      `CHK({cop_unusable_exc, reserved_instr_exc, walk_len + 8'(busy), invalid_vec}, exp_v)
      walk_len <= 8'h00;
    end
    if (done_hw) begin
      exp_w = (exp_h_q.size() > 0) ? exp_h_q.pop_front() : 'x;
      `CHK(invalid_vec_hw, exp_w)
    end
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys) reset = 1'b0;
    repeat (2) @(negedge clk_sys);
    `CHK({invalidate_support_field, fixed_page_ways_field, fixed_page_sets_field, invalid_vec}, {TIU_IE_SW, 8'(W - TIU_WAYS_BIAS), 8'h02, {N{1'b1}}})
    `CHK(ie_hw, TIU_IE_HW)
    // two requests back to back each round, the second taken once both units idle
    for (int k = 0; k < 16; k++) begin
      for (int e = 0; e < N; e++) wr(e);
      for (int j = 0; j < 2; j++) begin
        rnd = lfsr(rnd);
        op(rnd[0], types[(k + j) % 6], rnd[4:2], {6'h00, rnd[6:5]}, (k % 7) != 3);
      end
    end
    // whole split array flushed by software: variable range, then each fixed set
    for (int e = 0; e < N; e++) wr(e);
    for (int s = 0; s < 3; s++) op(1'b1, TIU_MT_SPLIT, (s == 0) ? 0 : VS + (s - 1) * W, 8'h00, 1'b1);
    repeat (20) @(negedge clk_sys);
    `CHK(exp_q.size(), 0)
    `CHK(exp_h_q.size(), 0)
    `CHK(invalid_vec, {N{1'b1}})
    test_done();
  end

  // hang guard, well past the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
